//--- design/fsb_regs.svh
// Register selectors, bit positions and reset values of the fault status bank
`ifndef FSB_REGS_SVH
`define FSB_REGS_SVH

// Selector pattern carried in address bits [6:2]
`define FSB_SEL_GLOBAL 5'h06
`define FSB_SEL_OC_LOW 5'h16

// Global fault status bit positions
`define FSB_BIT_SPI_ERR 7
`define FSB_BIT_LOAD_FAULT 6
`define FSB_BIT_UNDERVOLT 5
`define FSB_BIT_OVERVOLT 4
`define FSB_BIT_NO_POR 3
`define FSB_BIT_THERM_SD 2
`define FSB_BIT_THERM_PW 1
`define FSB_BIT_RSVD 0

// Reset values
`define FSB_STATUS_RST 8'h00
`define FSB_BIT_RST 1'h0
`define FSB_SYNC_RST 1'h0

// Sticky bits of the global register that hardware sets and a clear resets
`define FSB_GLOBAL_STICKY_MASK 8'hB6

`endif

//--- design/fsb_pkg.sv
// Types shared by the fault status bank
package fsb_pkg;

  // Address byte of one serial command
  typedef struct packed {
    logic clear_select_bit;
    logic [4:0] sel;
    logic chain_response_bit;
    logic frame_one;
  } fsb_cmd_t;

  // Analog detector levels, asynchronous to core_clk
  typedef struct packed {
    logic undervolt;
    logic overvolt;
    logic therm_sd;
    logic therm_pw;
    logic [7:0] overcurrent;
  } fsb_det_t;

  // Answer to one command
  typedef struct packed {
    logic hit;
    logic chain_response_bit;
    logic [7:0] data;
  } fsb_rsp_t;

endpackage

//--- design/fsb_sync.sv
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
`include "fsb_regs.svh"
module fsb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= {W{`FSB_SYNC_RST}};
      sync_out <= {W{`FSB_SYNC_RST}};
    end else begin
      meta_r <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end
endmodule // fsb_sync

//--- design/fsb_sticky.sv
// Bank of sticky flags where a set in the clearing cycle wins
`timescale 1ns/1ps
`include "fsb_regs.svh"
module fsb_sticky #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Per-flag controls
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  // Flags
  output logic [W-1:0] flag_nxt,
  output logic [W-1:0] flag_q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // An event in the clearing cycle re-arms the flag so it is never lost
      always_comb begin
        flag_nxt[i] = (flag_q[i] & ~clr_in[i]) | set_in[i];
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= {W{`FSB_BIT_RST}};
    end else begin
      flag_q <= flag_nxt;
    end
  end
endmodule // fsb_sticky

//--- design/fsb_status_bank.sv
// Global fault and lower overcurrent status registers with read and clear commands
`timescale 1ns/1ps
`include "fsb_regs.svh"

// Operation
// RULE1: protocol error sets sticky top bit
// RULE2: bit six ORs all load faults
// RULE3: clear leaves load summary unchanged
// RULE4: summary drops once all faults cleared
// RULE5: undervoltage latches bit five, disables outputs
// RULE6: overvoltage latches bit four, disables outputs
// RULE7: bit three zero after power-on reset
// RULE8: thermal shutdown latches bit two, disables outputs
// RULE9: prewarning sets bit one, outputs stay
// RULE10: bit zero always reads zero
// RULE11: all flags zero after reset
// RULE12: overcurrent flags ordered bridge four high first
// RULE13: overcurrent latches flag, switch off until cleared
// RULE14: global register selected by pattern 00110
// RULE15: overcurrent register selected by pattern 10110
// RULE16: top address bit zero reads unchanged
// RULE17: top address bit one clears flags
// RULE18: flags never self-clear
// RULE19: event during clear keeps flag set
// RULE20: detectors synchronised before setting flags
module fsb_status_bank (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Command from the serial front end
  input wire logic cmd_valid,
  input wire fsb_pkg::fsb_cmd_t cmd_byte,
  input wire logic frame_err,
  // Answer
  output logic rsp_valid,
  output fsb_pkg::fsb_rsp_t rsp,
  // Detectors and summaries of other registers
  input wire fsb_pkg::fsb_det_t det_raw,
  input wire logic open_load_any,
  input wire logic overcurrent_other_any,
  // Status and protection
  output logic [7:0] global_fault_status,
  output logic [7:0] overcurrent_flags_bank_one,
  output logic bridge_disable_all,
  output logic [7:0] switch_off
);
  import fsb_pkg::*;

  fsb_det_t det_s;
  logic sel_global;
  logic sel_oc_low;
  logic clr_global;
  logic clr_oc_low;
  logic [7:0] glob_set;
  logic [7:0] glob_clr;
  logic [7:0] glob_nxt;
  logic [7:0] glob_q;
  logic [7:0] oc_nxt;
  logic [7:0] oc_q;
  logic load_fault_summary_r;
  logic load_fault_summary_nxt;
  logic no_poweron_reset_flag_r;
  logic no_poweron_reset_flag_nxt;
  logic disable_all_r;
  logic disable_all_nxt;
  logic rsp_valid_r;
  logic rsp_valid_nxt;
  fsb_rsp_t rsp_r;
  fsb_rsp_t rsp_nxt;
  logic [7:0] global_view;

  // Analog detectors are asynchronous to core_clk
  fsb_sync #(
    .W($bits(fsb_det_t))
  ) u_det_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in(det_raw),
    .sync_out(det_s)
  ); // RULE20

  // Address decode; bit zero of a valid address byte is always one
  always_comb begin
    sel_global = cmd_valid && cmd_byte.frame_one && (cmd_byte.sel == `FSB_SEL_GLOBAL); // RULE14
    sel_oc_low = cmd_valid && cmd_byte.frame_one && (cmd_byte.sel == `FSB_SEL_OC_LOW); // RULE15
    clr_global = sel_global && cmd_byte.clear_select_bit; // RULE17
    clr_oc_low = sel_oc_low && cmd_byte.clear_select_bit; // RULE17
  end

  // Global sticky flags; only a clear command or arst_n resets them
  always_comb begin
    glob_set = `FSB_STATUS_RST;
    glob_set[`FSB_BIT_SPI_ERR] = frame_err; // RULE1
    glob_set[`FSB_BIT_UNDERVOLT] = det_s.undervolt; // RULE5
    glob_set[`FSB_BIT_OVERVOLT] = det_s.overvolt; // RULE6
    glob_set[`FSB_BIT_THERM_SD] = det_s.therm_sd; // RULE8
    glob_set[`FSB_BIT_THERM_PW] = det_s.therm_pw; // RULE9
    glob_clr = clr_global ? `FSB_GLOBAL_STICKY_MASK : `FSB_STATUS_RST; // RULE17 RULE18
  end

  fsb_sticky #(
    .W(8)
  ) u_global_flags (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .set_in(glob_set),
    .clr_in(glob_clr),
    .flag_nxt(glob_nxt),
    .flag_q(glob_q)
  ); // RULE19

  // Overcurrent flags of bridges one to four, bit order as the detector vector
  fsb_sticky #(
    .W(8)
  ) u_oc_flags (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .set_in(det_s.overcurrent),
    .clr_in({8{clr_oc_low}}),
    .flag_nxt(oc_nxt),
    .flag_q(oc_q)
  ); // RULE12 RULE13 RULE19

  // Summary, power-on marker and global disable
  always_comb begin
    load_fault_summary_nxt = (|oc_nxt) | open_load_any |
                             overcurrent_other_any; // RULE2 RULE3 RULE4
    // Marker stays zero until software acknowledges the reset by clearing it
    no_poweron_reset_flag_nxt = no_poweron_reset_flag_r | clr_global; // RULE7
    disable_all_nxt = glob_nxt[`FSB_BIT_UNDERVOLT] | glob_nxt[`FSB_BIT_OVERVOLT] |
                      glob_nxt[`FSB_BIT_THERM_SD]; // RULE5 RULE6 RULE8
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      load_fault_summary_r <= `FSB_BIT_RST; // RULE11
      no_poweron_reset_flag_r <= `FSB_BIT_RST; // RULE11
      disable_all_r <= `FSB_BIT_RST;
    end else begin
      load_fault_summary_r <= load_fault_summary_nxt;
      no_poweron_reset_flag_r <= no_poweron_reset_flag_nxt;
      disable_all_r <= disable_all_nxt;
    end
  end

  // Assembled view of the global register
  always_comb begin
    global_view = glob_q & `FSB_GLOBAL_STICKY_MASK;
    global_view[`FSB_BIT_LOAD_FAULT] = load_fault_summary_r;
    global_view[`FSB_BIT_NO_POR] = no_poweron_reset_flag_r;
    global_view[`FSB_BIT_RSVD] = `FSB_BIT_RST; // RULE10
  end

  // Answer carries the contents before any clear of the same command
  always_comb begin
    rsp_valid_nxt = cmd_valid;
    rsp_nxt.hit = sel_global | sel_oc_low;
    rsp_nxt.chain_response_bit = cmd_byte.chain_response_bit;
    if (sel_global) begin
      rsp_nxt.data = global_view; // RULE16
    end else if (sel_oc_low) begin
      rsp_nxt.data = oc_q; // RULE16
    end else begin
      rsp_nxt.data = `FSB_STATUS_RST;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid_r <= `FSB_BIT_RST;
      rsp_r <= '0;
    end else begin
      rsp_valid_r <= rsp_valid_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp = rsp_r;
  assign global_fault_status = global_view;
  assign overcurrent_flags_bank_one = oc_q;
  assign bridge_disable_all = disable_all_r;
  assign switch_off = oc_q; // RULE13

  a_spi_err_set: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE1
    frame_err |=> global_view[`FSB_BIT_SPI_ERR])
    else $error("protocol error did not set flag");

  a_load_sum_or: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE2
    ##1 load_fault_summary_r == ((|oc_q) | $past(open_load_any) |
    $past(overcurrent_other_any)))
    else $error("load summary differs from fault OR");

  a_load_keep_clr: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE3
    (clr_global && (|oc_q) && !clr_oc_low) |=> load_fault_summary_r)
    else $error("global clear dropped load summary");

  a_load_auto_zero: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE4
    (clr_oc_low && !(|det_s.overcurrent) && !open_load_any && !overcurrent_other_any)
    |=> !load_fault_summary_r)
    else $error("load summary not released");

  a_uv_disable: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE5
    det_s.undervolt |=> global_view[`FSB_BIT_UNDERVOLT] && bridge_disable_all)
    else $error("undervoltage not latched or outputs on");

  a_ov_disable: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE6
    det_s.overvolt |=> global_view[`FSB_BIT_OVERVOLT] && bridge_disable_all)
    else $error("overvoltage not latched or outputs on");

  a_no_poweron_reset_flag_sets: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE7
    clr_global |=> global_view[`FSB_BIT_NO_POR] ##1 global_view[`FSB_BIT_NO_POR])
    else $error("power-on marker not set by clear");

  a_tsd_disable: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE8
    det_s.therm_sd |=> global_view[`FSB_BIT_THERM_SD] && bridge_disable_all)
    else $error("thermal shutdown not latched or outputs on");

  a_tpw_no_off: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE9
    (global_view[`FSB_BIT_THERM_PW] && !global_view[`FSB_BIT_UNDERVOLT] &&
    !global_view[`FSB_BIT_OVERVOLT] && !global_view[`FSB_BIT_THERM_SD])
    |-> !bridge_disable_all)
    else $error("prewarning disabled outputs");

  a_rsvd_zero: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE10
    rsp_valid && $past(sel_global) |-> !rsp.data[`FSB_BIT_RSVD])
    else $error("reserved bit read as one");

  a_oc_latch_off: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE12 RULE13
    (|det_s.overcurrent) |=> ((switch_off & $past(det_s.overcurrent)) ==
    $past(det_s.overcurrent)))
    else $error("overcurrent not latched or switch on");

  a_read_keeps: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE16 RULE18
    (sel_oc_low && !cmd_byte.clear_select_bit) |=> oc_q == ($past(oc_q) |
    $past(det_s.overcurrent)))
    else $error("read changed overcurrent flags");

  a_clear_oc: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE17 RULE19
    clr_oc_low |=> oc_q == $past(det_s.overcurrent))
    else $error("overcurrent clear wrong");

  a_uv_set_wins: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE19
    (clr_global && det_s.undervolt) |=> global_view[`FSB_BIT_UNDERVOLT])
    else $error("undervoltage lost during clear");

  a_sync_delay: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE20
    det_raw.therm_sd |-> ##3 global_view[`FSB_BIT_THERM_SD])
    else $error("detector not latched after synchroniser");

  a_sel_decode: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE14
    (cmd_valid && cmd_byte.frame_one && cmd_byte.sel == `FSB_SEL_GLOBAL) |=>
    rsp_valid && rsp.hit)
    else $error("global register address not decoded");

  // Decode and answer checks
  a_sel_decode_oc: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE15
    (cmd_valid && cmd_byte.frame_one && cmd_byte.sel == `FSB_SEL_OC_LOW) |=>
    rsp_valid && rsp.hit)
    else $error("overcurrent register address not decoded");

  a_bad_frame: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE14
    (cmd_valid && !cmd_byte.frame_one) |=>
    rsp_valid && !rsp.hit && rsp.data == `FSB_STATUS_RST)
    else $error("address without frame bit was answered");

  a_bad_sel: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE14 RULE15
    (cmd_valid && cmd_byte.sel != `FSB_SEL_GLOBAL && cmd_byte.sel != `FSB_SEL_OC_LOW) |=>
    !rsp.hit && rsp.data == `FSB_STATUS_RST)
    else $error("unknown address was answered");

  a_rsp_pulse: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE16
    rsp_valid |-> $past(cmd_valid))
    else $error("answer strobe without command");

  a_rsp_follow: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE16
    cmd_valid |=> rsp_valid)
    else $error("command earned no answer strobe");

  a_glob_data: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE16
    sel_global |=> rsp.data == $past(global_view))
    else $error("global answer differs from register");

  a_oc_data: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE16
    sel_oc_low |=> rsp.data == $past(oc_q))
    else $error("overcurrent answer differs from register");

  a_chain_echo: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE14
    cmd_valid |=> rsp.chain_response_bit == $past(cmd_byte.chain_response_bit))
    else $error("chain bit not echoed");

  // Latching and clearing checks
  a_glob_no_self: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE18
    !clr_global |=> (glob_q & $past(glob_q)) == $past(glob_q))
    else $error("global flag cleared without command");

  a_oc_no_self: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE18
    !clr_oc_low |=> (oc_q & $past(oc_q)) == $past(oc_q))
    else $error("overcurrent flag cleared without command");

  a_switch_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE13
    !clr_oc_low |=> (switch_off & $past(switch_off)) == $past(switch_off))
    else $error("switch released without clear");

  a_oc_set_wins: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE19
    (clr_oc_low && (|det_s.overcurrent)) |=> (|oc_q))
    else $error("overcurrent lost during clear");

  a_no_poweron_reset_flag_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE7
    no_poweron_reset_flag_r |=> no_poweron_reset_flag_r)
    else $error("power-on marker dropped without reset");

  a_no_poweron_reset_flag_low: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE7
    (!no_poweron_reset_flag_r && !clr_global) |=> !no_poweron_reset_flag_r)
    else $error("power-on marker set without clear");

  a_clear_glob: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE17
    (clr_global && !frame_err && !det_s.undervolt && !det_s.overvolt && !det_s.therm_sd &&
    !det_s.therm_pw) |=> (global_view & `FSB_GLOBAL_STICKY_MASK) == `FSB_STATUS_RST)
    else $error("global clear left a flag set");

  a_tpw_latch: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE9
    det_s.therm_pw |=> global_view[`FSB_BIT_THERM_PW])
    else $error("prewarning not latched");

  a_oc_sum_set: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE2
    (|oc_q) |-> load_fault_summary_r)
    else $error("overcurrent flag missing from summary");

  a_other_sum: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE2
    (open_load_any || overcurrent_other_any) |=> load_fault_summary_r)
    else $error("other load fault missing from summary");

  // Reset and protection checks
  a_disable_eq: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE5 RULE6 RULE8
    bridge_disable_all == (global_view[`FSB_BIT_UNDERVOLT] | global_view[`FSB_BIT_OVERVOLT] |
    global_view[`FSB_BIT_THERM_SD]))
    else $error("global disable differs from latched faults");

  a_reset_clean: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE11
    $rose(arst_n) |-> global_view == `FSB_STATUS_RST && oc_q == `FSB_STATUS_RST &&
    !rsp_valid)
    else $error("flag not zero after reset");
endmodule // fsb_status_bank

//--- tb/fsb_host_model.sv
// Host model that sends address bytes to the fault status bank
`timescale 1ns/1ps
module fsb_host_model (
  // Clock
  input wire logic core_clk,
  // Command
  output logic cmd_valid,
  output fsb_pkg::fsb_cmd_t cmd_byte,
  output logic frame_err,
  // Answer
  input wire logic rsp_valid,
  input wire fsb_pkg::fsb_rsp_t rsp
);
  import fsb_pkg::*;
  fsb_rsp_t last_rsp;
  logic got;
  logic chain_bit;
  logic frame_bit;

  initial begin
    cmd_valid = 1'h0;
    cmd_byte = 8'h00;
    frame_err = 1'h0;
    got = 1'h0;
    last_rsp = 10'h000;
    chain_bit = 1'h0;
    frame_bit = 1'h1;
  end

  // One address byte; the answer is taken half a cycle after the taking edge
  task automatic send(input logic clr, input logic [4:0] sel);
    @(negedge core_clk);
    cmd_valid = 1'h1;
    cmd_byte = {clr, sel, chain_bit, frame_bit};
    @(negedge core_clk);
    cmd_valid = 1'h0;
    got = rsp_valid;
    last_rsp = rsp;
    // Idle byte is inverted so a design that ignores the strobe is caught
    cmd_byte = ~cmd_byte;
  endtask

  // One-cycle protocol error pulse from the serial front end
  task automatic proto_err;
    @(negedge core_clk);
    frame_err = 1'h1;
    @(negedge core_clk);
    frame_err = 1'h0;
  endtask
endmodule // fsb_host_model

//--- tb/tb_top.sv
// Self-checking bench for the fault status bank
`timescale 1ns/1ps
`include "fsb_regs.svh"
module tb_top;
  import fsb_pkg::*;
  logic core_clk, arst_n, cmd_valid, frame_err, rsp_valid, bridge_disable_all;
  logic open_load_any, overcurrent_other_any;
  fsb_cmd_t cmd_byte;
  fsb_rsp_t rsp;
  fsb_det_t det_raw;
  logic [7:0] global_fault_status, overcurrent_flags_bank_one, switch_off;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;

  fsb_status_bank u_fsb_status_bank (.core_clk(core_clk), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .frame_err(frame_err),
    .rsp_valid(rsp_valid), .rsp(rsp), .det_raw(det_raw), .open_load_any(open_load_any),
    .overcurrent_other_any(overcurrent_other_any), .global_fault_status(global_fault_status),
    .overcurrent_flags_bank_one(overcurrent_flags_bank_one),
    .bridge_disable_all(bridge_disable_all), .switch_off(switch_off));

  fsb_host_model u_fsb_host_model (.core_clk(core_clk), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .frame_err(frame_err), .rsp_valid(rsp_valid), .rsp(rsp));

  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Command plus judgement of the single answer it earns
  task automatic rd(input logic clr, input logic [4:0] sel, input logic hit,
                    input logic [7:0] data);
    u_fsb_host_model.send(clr, sel);
    chk({9'h000, u_fsb_host_model.got}, 10'h001);
    chk(u_fsb_host_model.last_rsp, {hit, u_fsb_host_model.chain_bit, data});
  endtask

  task automatic t_reset;
    chk({2'h0, global_fault_status}, 10'h000);
    chk({2'h0, overcurrent_flags_bank_one}, 10'h000);
    rd(1'h0, `FSB_SEL_GLOBAL, 1'h1, 8'h00);
    rd(1'h0, 5'h0A, 1'h0, 8'h00);
    rd(1'h0, `FSB_SEL_OC_LOW, 1'h1, 8'h00);
    rd(1'h1, `FSB_SEL_GLOBAL, 1'h1, 8'h00);
    chk({2'h0, global_fault_status}, 10'h008);
  endtask

  task automatic t_serr;
    u_fsb_host_model.proto_err();
    @(negedge core_clk);
    chk({2'h0, global_fault_status}, 10'h088);
    rd(1'h0, `FSB_SEL_GLOBAL, 1'h1, 8'h88);
    rd(1'h1, `FSB_SEL_GLOBAL, 1'h1, 8'h88);
    chk({2'h0, global_fault_status}, 10'h008);
  endtask

  // Undervoltage, overvoltage, shutdown, prewarning; the last leaves outputs on
  task automatic t_supply;
    int pos [4] = '{5, 4, 2, 1};
    logic [9:0] exp;
    for (int k = 0; k < 4; k++) begin
      exp = 10'h008 | (10'h001 << pos[k]);
      det_raw[11-k] = 1'h1;
      repeat (2) @(negedge core_clk);
      chk({2'h0, global_fault_status}, 10'h008);
      @(negedge core_clk);
      det_raw[11-k] = 1'h0;
      chk({2'h0, global_fault_status}, exp);
      chk({9'h000, bridge_disable_all}, {9'h000, k < 3});
      repeat (4) @(negedge core_clk);
      chk({2'h0, global_fault_status}, exp);
      rd(1'h1, `FSB_SEL_GLOBAL, 1'h1, exp[7:0]);
      @(negedge core_clk);
      chk({1'h0, bridge_disable_all, global_fault_status}, 10'h008);
    end
  endtask

  // Every overcurrent bit in turn, with the summary through both clears
  task automatic t_oc;
    for (int i = 0; i < 8; i++) begin
      det_raw.overcurrent[i] = 1'h1;
      repeat (3) @(negedge core_clk);
      det_raw.overcurrent[i] = 1'h0;
      @(negedge core_clk);
      chk({2'h0, overcurrent_flags_bank_one}, 10'h001 << i);
      chk({2'h0, switch_off}, 10'h001 << i);
      chk({2'h0, global_fault_status}, 10'h048);
      rd(1'h1, `FSB_SEL_GLOBAL, 1'h1, 8'h48);
      chk({2'h0, global_fault_status}, 10'h048);
      rd(1'h1, `FSB_SEL_OC_LOW, 1'h1, 8'h01 << i);
      @(negedge core_clk);
      chk({2'h0, global_fault_status}, 10'h008);
      chk({2'h0, switch_off}, 10'h000);
    end
  endtask

  task automatic t_setwins;
    det_raw.overcurrent[7] = 1'h1;
    open_load_any = 1'h1;
    repeat (3) @(negedge core_clk);
    rd(1'h1, `FSB_SEL_OC_LOW, 1'h1, 8'h80);
    chk({2'h0, overcurrent_flags_bank_one}, 10'h080);
    det_raw.overcurrent[7] = 1'h0;
    repeat (3) @(negedge core_clk);
    rd(1'h1, `FSB_SEL_OC_LOW, 1'h1, 8'h80);
    repeat (2) @(negedge core_clk);
    chk({2'h0, global_fault_status}, 10'h048);
    open_load_any = 1'h0;
    overcurrent_other_any = 1'h1;
    repeat (2) @(negedge core_clk);
    chk({2'h0, global_fault_status}, 10'h048);
    overcurrent_other_any = 1'h0;
    repeat (2) @(negedge core_clk);
    chk({2'h0, global_fault_status}, 10'h008);
  endtask

  // Reset in mid-run wipes every flag, the power-on marker too
  task automatic t_rst_mid;
    det_raw = 12'h801;
    repeat (3) @(negedge core_clk);
    chk({2'h0, global_fault_status}, 10'h068);
    det_raw = 12'h000;
    arst_n = 1'h0;
    @(negedge core_clk);
    chk({1'h0, bridge_disable_all, global_fault_status}, 10'h000);
    chk({2'h0, switch_off}, 10'h000);
    arst_n = 1'h1;
    u_fsb_host_model.chain_bit = 1'h1;
    rd(1'h0, `FSB_SEL_GLOBAL, 1'h1, 8'h00);
    u_fsb_host_model.frame_bit = 1'h0;
    rd(1'h0, `FSB_SEL_GLOBAL, 1'h0, 8'h00);
    u_fsb_host_model.chain_bit = 1'h0;
    u_fsb_host_model.frame_bit = 1'h1;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      report_and_stop;
    end
  end

  initial begin
    arst_n = 1'h0;
    det_raw = 12'h000;
    open_load_any = 1'h0;
    overcurrent_other_any = 1'h0;
    repeat (6) @(negedge core_clk);
    arst_n = 1'h1;
    t_reset;
    t_serr;
    t_supply;
    t_oc;
    t_setwins;
    t_rst_mid;
    report_and_stop;
  end
endmodule // tb_top
